// File: logic/event_counter_consts.svh
// Constants for the threshold event counter: register offsets, field layout, reset values.
// Included by the package and the design; definitions only.
`ifndef EVENT_COUNTER_CONSTS_SVH
`define EVENT_COUNTER_CONSTS_SVH
`define OFS_CTRL 12'h000
`define OFS_THRESH 12'h004
`define OFS_HYST 12'h008
`define OFS_LIMIT 12'h00C
`define OFS_RSTSEL 12'h010
`define OFS_COUNT 12'h014
`define OFS_FLAGS 12'h018
`define OFS_IRQ_STAT 12'h01C
`define OFS_IRQ_MASK 12'h020
`define OFS_FORCE 12'h024
`define OFS_CHSEL 12'h028
`define CTRL_ENABLE 0
`define CTRL_SW_CLEAR 1
`define FLAG_TRIG 0
`define FLAG_LIMIT 1
`define EV_LIMIT 0
`define EV_RESET 1
`define LIMIT_RESET 32'h00000005
`define THRESH_RESET 32'h00000001
`define HYST_RESET 32'h00000000
`define RSTSEL_RESET 32'h00000000
`define NUM_EVENTS 2
`define FB_FIRST_BIT 16
`endif

// File: logic/event_counter_pkg.sv
// Types shared by the threshold event counter.
// Assumes the constants header is on the include path.
`include "event_counter_consts.svh"
package event_counter_pkg;
   typedef logic [31:0] word_t;
   typedef logic [11:0] addr_t;
   typedef enum logic [1:0] {
      ST_IDLE = 2'b00,
      ST_ACCESS = 2'b01
   } bus_state_t;
endpackage

// File: logic/threshold_event_counter.sv
// Threshold trigger plus rising-edge event counter with limit flag, APB registers and one interrupt.
// Assumes an APB master on clk_sys; force samples and flags come from the same clock domain,
// digital and fieldbus inputs come from pins and are synchronised here.
// Only the first sixteen fieldbus bits are selectable as reset; channel flags have their own select.
//
// Design decisions made here: the register offsets and the APB register port.
`timescale 1ns/1ps
`include "event_counter_consts.svh"
module threshold_event_counter #(
   parameter int CNT_W = 32, // Counter width
   parameter int DIN_W = 16, // Physical digital inputs
   parameter int FB_W = 32, // Fieldbus control-word bits
   parameter int CH_W = 32, // Calculation channel flags
   parameter int DOUT_W = 16, // Digital outputs
   parameter int DOUT_SEL = 1 // Output driven by limit flag (index 1 is output two)
) (
   input wire logic clk_sys, // System clock, 200 MHz
   input wire logic rst, // Synchronous reset, active high
   input wire logic psel, // APB select
   input wire logic penable, // APB enable
   input wire logic pwrite, // APB direction
   input wire event_counter_pkg::addr_t paddr, // APB byte address
   input wire event_counter_pkg::word_t pwdata, // APB write data
   output event_counter_pkg::word_t prdata, // APB read data
   output logic pready, // APB ready
   output logic pslverr, // APB error on unmapped address
   input wire logic signed [31:0] force_value, // Measured force sample
   input wire logic force_valid, // Force sample strobe
   input wire logic [DIN_W-1:0] din_pin, // Digital input pins
   input wire logic [FB_W-1:0] fb_ctrl, // Fieldbus control word bits
   input wire logic [CH_W-1:0] chan_flags, // Flags of other channels
   output logic trigger_pulse_flag, // Trigger stage result
   output logic count_limit_flag, // Counter limit result
   output logic [DOUT_W-1:0] dout, // Digital outputs
   output logic irq // Level interrupt
);
   import event_counter_pkg::*;

   // Select word for pins and fieldbus bits; channel flags have a word of their own
   localparam int RSEL_W = DIN_W + FB_W;

   // Configuration, counter and bus state
   logic enable;
   logic signed [31:0] thresh;
   logic [31:0] hyst;
   logic [CNT_W-1:0] limit;
   logic [RSEL_W-1:0] rst_sel;
   logic [CH_W-1:0] ch_sel;
   logic [CNT_W-1:0] count;
   logic [`NUM_EVENTS-1:0] irq_stat;
   logic [`NUM_EVENTS-1:0] irq_mask;
   logic [`NUM_EVENTS-1:0] events;
   logic trig_d;
   logic sw_clear;
   logic [DIN_W-1:0] din_s1, din_s2;
   logic [FB_W-1:0] fb_s1, fb_s2;
   logic counter_reset;
   logic rise;
   logic limit_hit;
   logic signed [32:0] release_lvl;
   bus_state_t bus_st;
   logic wr_stb, rd_stb;
   logic addr_ok;
   word_t rd_mux;

   // Two-stage synchronisers on the pin and fieldbus inputs
   // Pins change anywhere in the cycle, so only the second stage is read
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         din_s1 <= '0;
         din_s2 <= '0;
         fb_s1 <= '0;
         fb_s2 <= '0;
      end else begin
         din_s1 <= din_pin;
         din_s2 <= din_s1;
         fb_s1 <= fb_ctrl;
         fb_s2 <= fb_s1;
      end
   end

   // APB: two wait states so decoding and read mux stay registered
   // Ready still high blocks a second take of the same transfer
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         bus_st <= ST_IDLE;
      end else begin
         case (bus_st)
            ST_IDLE: if (psel && penable && !pready) bus_st <= ST_ACCESS;
            ST_ACCESS: bus_st <= ST_IDLE;
            default: bus_st <= ST_IDLE;
         endcase
      end
   end

   assign wr_stb = (bus_st == ST_ACCESS) && psel && penable && pwrite && addr_ok;
   assign rd_stb = (bus_st == ST_ACCESS) && psel && penable && !pwrite && addr_ok;

   // Address decode and read mux
   // Unmapped offsets fall to the default and raise the error flag
   always_comb begin
      addr_ok = 1'b1;
      rd_mux = '0;
      case (paddr)
         `OFS_CTRL: rd_mux = {31'h00000000, enable};
         `OFS_THRESH: rd_mux = thresh;
         `OFS_HYST: rd_mux = hyst;
         `OFS_LIMIT: rd_mux = 32'(limit);
         `OFS_RSTSEL: rd_mux = 32'(rst_sel);
         `OFS_CHSEL: rd_mux = 32'(ch_sel);
         `OFS_COUNT: rd_mux = 32'(count);
         `OFS_FLAGS: rd_mux = {30'h00000000, count_limit_flag, trigger_pulse_flag};
         `OFS_IRQ_STAT: rd_mux = {30'h00000000, irq_stat};
         `OFS_IRQ_MASK: rd_mux = {30'h00000000, irq_mask};
         `OFS_FORCE: rd_mux = force_value;
         default: addr_ok = 1'b0;
      endcase
   end

   // Answer registered; ready stands one cycle
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         pready <= 1'b0;
         pslverr <= 1'b0;
         prdata <= '0;
      end else begin
         pready <= (bus_st == ST_ACCESS) && psel && penable;
         pslverr <= (bus_st == ST_ACCESS) && psel && penable && !addr_ok;
         prdata <= ((bus_st == ST_ACCESS) && !pwrite) ? rd_mux : '0;
      end
   end

   // Configuration registers; software clear is a self-clearing pulse
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         enable <= 1'b1;
         thresh <= `THRESH_RESET;
         hyst <= `HYST_RESET;
         limit <= CNT_W'(`LIMIT_RESET);
         rst_sel <= RSEL_W'(`RSTSEL_RESET);
         ch_sel <= CH_W'(`RSTSEL_RESET);
         irq_mask <= '0;
         sw_clear <= 1'b0;
      end else begin
         sw_clear <= 1'b0;
         if (wr_stb) begin
            case (paddr)
               `OFS_CTRL: begin
                  enable <= pwdata[`CTRL_ENABLE];
                  sw_clear <= pwdata[`CTRL_SW_CLEAR];
               end
               `OFS_THRESH: thresh <= pwdata;
               `OFS_HYST: hyst <= pwdata;
               `OFS_LIMIT: limit <= CNT_W'(pwdata);
               `OFS_RSTSEL: rst_sel <= RSEL_W'(pwdata);
               `OFS_CHSEL: ch_sel <= CH_W'(pwdata);
               `OFS_IRQ_MASK: irq_mask <= pwdata[`NUM_EVENTS-1:0];
               default: ;
            endcase
         end
      end
   end

   // Trigger with hysteresis; wide compare avoids wrap of threshold minus hysteresis
   // Between release level and threshold the flag keeps its last state
   assign release_lvl = 33'(thresh) - $signed({1'b0, hyst});
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         trigger_pulse_flag <= 1'b0;
      end else if (force_valid) begin
         if (33'(force_value) > 33'(thresh)) begin
            trigger_pulse_flag <= 1'b1;
         end else if (33'(force_value) < release_lvl) begin
            trigger_pulse_flag <= 1'b0;
         end
      end
   end

   // Reset sources: pin inputs, the first sixteen fieldbus bits, other channel flags; each selectable
   assign counter_reset = sw_clear || |({fb_s2, din_s2} & rst_sel)
      || |(chan_flags & ch_sel);

   always_ff @(posedge clk_sys) begin
      if (rst) begin
         trig_d <= 1'b0;
      end else begin
         trig_d <= trigger_pulse_flag;
      end
   end
   // Detector resets low like the flag, so no false edge follows reset
   assign rise = trigger_pulse_flag && !trig_d;

   // Counter saturates rather than wrapping back below the limit
   // Reset wins over a coincident edge; that edge is lost, not deferred
   always_ff @(posedge clk_sys) begin
      if (rst || counter_reset) begin
         count <= '0;
      end else if (enable && rise && count != '1) begin
         count <= count + CNT_W'(1);
      end
   end

   assign limit_hit = (count >= limit);

   // Limit flag and digital output follow the count one cycle later
   // Other outputs stay low; only the selected one carries the flag
   always_ff @(posedge clk_sys) begin
      if (rst || counter_reset) begin
         count_limit_flag <= 1'b0;
         dout <= '0;
      end else begin
         count_limit_flag <= limit_hit;
         dout <= '0;
         dout[DOUT_SEL] <= limit_hit;
      end
   end

   // Events: limit reached (rising), counter reset
   // Limit event is suppressed when a reset lands in the same cycle
   assign events[`EV_LIMIT] = limit_hit && !count_limit_flag && !counter_reset;
   assign events[`EV_RESET] = counter_reset;

   // Read of the status register clears; a new event in that cycle wins
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         irq_stat <= '0;
      end else begin
         irq_stat <= ((rd_stb && paddr == `OFS_IRQ_STAT) ? '0 : irq_stat) | events;
      end
   end

   // Interrupt level lags status by one cycle so the output stays a flop
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         irq <= 1'b0;
      end else begin
         irq <= |(irq_stat & irq_mask);
      end
   end

   // Assertions
   sequence s_rise;
      rise && enable && !counter_reset && count != '1;
   endsequence

   a_count_step: assert property (@(posedge clk_sys) disable iff (rst)
      s_rise |=> count == $past(count) + CNT_W'(1)) else $error("count did not step on edge");
   a_count_hold: assert property (@(posedge clk_sys) disable iff (rst)
      !rise && !counter_reset |=> count == $past(count)) else $error("count moved without edge");
   a_reset_zero: assert property (@(posedge clk_sys) disable iff (rst)
      counter_reset |=> count == '0 && !count_limit_flag) else $error("reset did not clear");
   a_limit_flag: assert property (@(posedge clk_sys) disable iff (rst)
      !counter_reset |=> count_limit_flag == ($past(count) >= $past(limit))) else $error("limit flag wrong");
   a_limit_five: assert property (@(posedge clk_sys) disable iff (rst)
      limit == CNT_W'(5) && count >= CNT_W'(5) && !counter_reset |=> count_limit_flag)
      else $error("flag low at five");
   a_trig_set: assert property (@(posedge clk_sys) disable iff (rst)
      force_valid && force_value > thresh |=> trigger_pulse_flag) else $error("trigger missed");
   a_trig_hyst: assert property (@(posedge clk_sys) disable iff (rst)
      trigger_pulse_flag && force_valid && 33'(force_value) >= release_lvl |=> trigger_pulse_flag)
      else $error("trigger released inside hysteresis");
   a_dout_two: assert property (@(posedge clk_sys) disable iff (rst)
      dout[DOUT_SEL] == count_limit_flag) else $error("output two not following flag");
   a_fb_reset: assert property (@(posedge clk_sys) disable iff (rst)
      fb_ctrl[0] && rst_sel[DIN_W] ##1 rst_sel[DIN_W] ##1 rst_sel[DIN_W] |=> count == '0)
      else $error("fieldbus reset lost");

   // Pin reset path: two synchroniser stages, then the count clears
   sequence s_pin_req;
      din_pin[0] && rst_sel[0] ##1 rst_sel[0] ##1 rst_sel[0];
   endsequence
   a_pin_reset: assert property (@(posedge clk_sys) disable iff (rst)
      s_pin_req |=> count == '0) else $error("pin reset lost");
   a_chan_reset: assert property (@(posedge clk_sys) disable iff (rst)
      (|(chan_flags & ch_sel)) |=> count == '0 && !count_limit_flag) else $error("channel reset lost");

   // Software clear: control write, one-cycle pulse, then zero
   sequence s_clear_write;
      wr_stb && paddr == `OFS_CTRL && pwdata[`CTRL_SW_CLEAR];
   endsequence
   sequence s_clear_done;
      sw_clear ##1 count == '0;
   endsequence
   a_sw_clear: assert property (@(posedge clk_sys) disable iff (rst)
      s_clear_write |=> s_clear_done) else $error("software clear lost");
   a_disabled_hold: assert property (@(posedge clk_sys) disable iff (rst)
      !enable && !counter_reset |=> count == $past(count)) else $error("count moved while disabled");

   // Trigger release and hold between samples
   a_trig_clear: assert property (@(posedge clk_sys) disable iff (rst)
      force_valid && 33'(force_value) < release_lvl |=> !trigger_pulse_flag)
      else $error("trigger not released");
   a_trig_idle: assert property (@(posedge clk_sys) disable iff (rst)
      !force_valid |=> $stable(trigger_pulse_flag)) else $error("trigger moved without sample");

   // Limit register and outputs
   a_write_lands: assert property (@(posedge clk_sys) disable iff (rst)
      wr_stb && paddr == `OFS_LIMIT |=> limit == CNT_W'($past(pwdata))) else $error("limit write lost");
   a_dout_rest: assert property (@(posedge clk_sys) disable iff (rst)
      (dout & ~(DOUT_W'(1) << DOUT_SEL)) == '0) else $error("unselected output driven");

   // Status: set by events, kept until read, read clears unless an event lands
   a_limit_event: assert property (@(posedge clk_sys) disable iff (rst)
      events[`EV_LIMIT] |=> irq_stat[`EV_LIMIT]) else $error("limit event lost");
   a_stat_sticky: assert property (@(posedge clk_sys) disable iff (rst)
      !(rd_stb && paddr == `OFS_IRQ_STAT) |=> (irq_stat & $past(irq_stat)) == $past(irq_stat))
      else $error("status bit lost");
   a_stat_clear: assert property (@(posedge clk_sys) disable iff (rst)
      rd_stb && paddr == `OFS_IRQ_STAT |=> irq_stat == $past(events)) else $error("status not cleared");
   a_irq_level: assert property (@(posedge clk_sys) disable iff (rst)
      1'b1 |=> irq == (|($past(irq_stat) & $past(irq_mask)))) else $error("interrupt level wrong");

   // APB: taken at one edge, ready two edges later, answer lasts one cycle
   sequence s_apb_take;
      psel && penable && !pready && bus_st == ST_IDLE;
   endsequence
   sequence s_apb_answer;
      bus_st == ST_ACCESS ##1 pready;
   endsequence
   a_apb_answer: assert property (@(posedge clk_sys) disable iff (rst)
      s_apb_take |=> s_apb_answer) else $error("bus answer late");
   a_err_unmapped: assert property (@(posedge clk_sys) disable iff (rst)
      s_apb_take ##1 !addr_ok |=> pslverr) else $error("unmapped access not refused");
   a_ready_pulse: assert property (@(posedge clk_sys) disable iff (rst)
      pready |=> !pready) else $error("ready longer than one cycle");
   a_err_ready: assert property (@(posedge clk_sys) disable iff (rst)
      pslverr |-> pready) else $error("error without ready");
   a_rdata_idle: assert property (@(posedge clk_sys) disable iff (rst)
      !pready |-> prdata == '0) else $error("read data outside answer");
endmodule

// File: verif/fb_master_model.sv
// Fieldbus master stand-in driving the control word bits.
// Assumes requests arrive on clk_sys from the bench.
`timescale 1ns/1ps
module fb_master_model (
   input wire logic clk_sys, // System clock
   input wire logic req, // Ask for a counter reset
   output logic [31:0] fb_ctrl // Control word bits
);
   int hold = 0;
   logic [31:0] w;
   initial fb_ctrl = 32'h0;
   // Bit 0 held long enough to pass the input synchroniser
   always @(posedge clk_sys) begin
      w = $urandom;
      hold <= req ? 6 : (hold > 0 ? hold - 1 : 0);
      fb_ctrl <= {w[31:1], hold > 0};
   end
endmodule

// File: verif/test_threshold_event_counter.sv
// Self-checking bench for the threshold event counter.
// Assumes the package and constants header are compiled first.
`timescale 1ns/1ps
`include "event_counter_consts.svh"
module test_threshold_event_counter;
   import event_counter_pkg::*;
   logic clk_sys = 0, rst = 1, psel = 0, penable = 0, pwrite = 0, force_valid = 0, fb_req = 0;
   logic pready, pslverr, trigger_pulse_flag, count_limit_flag, irq, e;
   addr_t paddr = 12'h0;
   word_t pwdata = 32'h0, prdata, q, r;
   logic signed [31:0] force_value = 0;
   logic [15:0] din_pin = 16'h0, dout;
   logic [31:0] fb_ctrl, chan_flags = 32'h0;
   int fail_count = 0, cmp_count = 0, k = 0;
   always #2.5 clk_sys = ~clk_sys;
   threshold_event_counter DUT (.clk_sys(clk_sys), .rst(rst), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .force_value(force_value), .force_valid(force_valid), .din_pin(din_pin),
      .fb_ctrl(fb_ctrl), .chan_flags(chan_flags), .trigger_pulse_flag(trigger_pulse_flag),
      .count_limit_flag(count_limit_flag), .dout(dout), .irq(irq));
   fb_master_model FB (.clk_sys(clk_sys), .req(fb_req), .fb_ctrl(fb_ctrl));
   task automatic chk(input word_t got, input word_t exp);
      cmp_count++;
      if (got !== exp) begin
         fail_count++;
         $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   // Slave latency is not assumed: wait on pready; only the watchdog ends a hang
   task automatic apb(input logic wr, input addr_t a, input word_t d);
      @(posedge clk_sys);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge clk_sys);
      penable <= 1'b1;
      do begin
         @(posedge clk_sys);
      end while (pready !== 1'b1);
      q = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic rd(input addr_t a, input word_t exp);
      apb(1'b0, a, 32'h0);
      chk(q, exp);
   endtask
   task automatic fv(input logic signed [31:0] v);
      @(posedge clk_sys);
      force_value <= v;
      force_valid <= 1'b1;
      @(posedge clk_sys);
      force_valid <= 1'b0;
      repeat (4) @(posedge clk_sys);
   endtask
   // One trigger rise then release, random depth either side
   task automatic pulse();
      fv(101 + $urandom % 500);
      fv(89 - $urandom % 500);
   endtask
   function automatic word_t exp_flags(input int cnt, input logic trg);
      return {30'h0, cnt >= `LIMIT_RESET, trg};
   endfunction
   task automatic final_report();
      $display("Mismatches %0d, comparisons %0d", fail_count, cmp_count);
      if (fail_count == 0 && cmp_count > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask
   // Whole run needs a few hundred cycles; this leaves ample margin
   initial begin
      #200000;
      fail_count++;
      final_report();
   end
   initial begin
      void'($urandom(32'h8BB6));
      r = $urandom;
      din_pin <= {r[15:1], 1'b0};
      chan_flags <= $urandom;
      repeat (5) @(posedge clk_sys);
      rst <= 1'b0;
      rd(`OFS_LIMIT, `LIMIT_RESET);
      rd(`OFS_THRESH, `THRESH_RESET);
      rd(`OFS_COUNT, 32'h0);
      apb(1'b0, 12'h0FC, 32'h0);
      chk(word_t'(e), 32'h1);
      apb(1'b1, `OFS_THRESH, 32'h64);
      apb(1'b1, `OFS_HYST, 32'hA);
      // Threshold and hysteresis edges
      fv(101);
      chk(word_t'(trigger_pulse_flag), 32'h1);
      fv(90);
      chk(word_t'(trigger_pulse_flag), 32'h1);
      fv(89);
      chk(word_t'(trigger_pulse_flag), 32'h0);
      fv(100);
      chk(word_t'(trigger_pulse_flag), 32'h0);
      repeat (3) pulse();
      rd(`OFS_COUNT, 32'h4);
      chk(word_t'(count_limit_flag), 32'h0);
      chk(word_t'(irq), 32'h0);
      pulse();
      chk(word_t'(count_limit_flag), 32'h1);
      chk(word_t'(dout), 32'h2);
      rd(`OFS_FLAGS, exp_flags(5, 1'b0));
      pulse();
      rd(`OFS_FLAGS, exp_flags(6, 1'b0));
      // Interrupt: unmasked, then cleared by read
      apb(1'b1, `OFS_IRQ_MASK, 32'h3);
      repeat (2) @(posedge clk_sys);
      chk(word_t'(irq), 32'h1);
      rd(`OFS_IRQ_STAT, 32'h1);
      repeat (3) @(posedge clk_sys);
      chk(word_t'(irq), 32'h0);
      // Pin reset
      apb(1'b1, `OFS_RSTSEL, 32'h1);
      din_pin[0] <= 1'b1;
      repeat (4) @(posedge clk_sys);
      din_pin[0] <= 1'b0;
      repeat (4) @(posedge clk_sys);
      rd(`OFS_COUNT, 32'h0);
      chk(word_t'(count_limit_flag), 32'h0);
      chk(word_t'(dout), 32'h0);
      rd(`OFS_IRQ_STAT, 32'h2);
      // Fieldbus bit 0 reset via select bit 16
      repeat (2) pulse();
      rd(`OFS_COUNT, 32'h2);
      apb(1'b1, `OFS_RSTSEL, 32'h10000);
      fb_req <= 1'b1;
      @(posedge clk_sys);
      fb_req <= 1'b0;
      repeat (10) @(posedge clk_sys);
      rd(`OFS_COUNT, 32'h0);
      // Channel flag reset on a random channel
      chan_flags <= 32'h0;
      k = $urandom % 32;
      apb(1'b1, `OFS_CHSEL, 32'h1 << k);
      rd(`OFS_CHSEL, 32'h1 << k);
      repeat (2) pulse();
      rd(`OFS_COUNT, 32'h2);
      chan_flags[k] <= 1'b1;
      @(posedge clk_sys);
      chan_flags[k] <= 1'b0;
      repeat (2) @(posedge clk_sys);
      rd(`OFS_COUNT, 32'h0);
      // Disabled count, then software clear
      apb(1'b1, `OFS_CTRL, 32'h0);
      pulse();
      rd(`OFS_COUNT, 32'h0);
      apb(1'b1, `OFS_CTRL, 32'h1);
      pulse();
      rd(`OFS_COUNT, 32'h1);
      apb(1'b1, `OFS_CTRL, 32'h3);
      rd(`OFS_COUNT, 32'h0);
      rd(`OFS_CTRL, 32'h1);
      final_report();
   end
endmodule
